// [core/mpr_bank.sv]
/*
  Page-zero register bank with clock divider, computation cycle timing,
  power averaging, RMS, pulse outputs and an interrupt pin.
  Assumes samples and calibration results arrive on REF_CLK from on-chip logic.
*/
`timescale 1ns/10ps
module mpr_bank
  import mpr_pkg::*;
(
  // Clock and reset
  input  wire logic      REF_CLK,
  input  wire logic      NRST,
  // Register port
  input  wire logic [4:0] ADDR,
  input  wire mpr_word_t WDATA,
  input  wire logic      WR,
  input  wire logic      RD,
  output mpr_word_t      RDATA,
  // Front end and calibration
  input  wire mpr_conv_s CONV,
  input  wire mpr_cal_s  CAL,
  input  wire logic      EPS_VALID,
  input  wire mpr_word_t EPS_MEAS,
  // Configuration seen by analog side
  output logic [6:0]     PHASE_DELAY_FIELD,
  output logic           CURRENT_GAIN_HIGH,
  // Clocks and pins
  output logic           INTERNAL_DIVIDED_CLOCK,
  output logic           PROCESSOR_CLOCK_OUTPUT,
  output logic [2:0]     ENERGY_PULSE_O,
  output logic [2:0]     ENERGY_PULSE_OE,
  output logic           INT_PIN,
  output logic           CALC_DONE_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic rst_s1_reg, rst_n;
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST) begin rst_s1_reg <= 1'b0; rst_n <= 1'b0; end
    else       begin rst_s1_reg <= 1'b1; rst_n <= rst_s1_reg; end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  mpr_word_t setup_reg, idc_reg, ign_reg, vdc_reg, vgn_reg, cyc_reg, prate_reg, eps_reg;
  mpr_word_t iinst_reg, vinst_reg, pinst_reg, pavg_reg, current_rms_result_reg, voltage_rms_result_reg;
  logic [NEV-1:0] stat_reg, mask_reg;

  wire wr_setup = WR && ADDR == A_SETUP;
  wire wr_idc   = WR && ADDR == A_IDC;
  wire wr_ign   = WR && ADDR == A_IGN;
  wire wr_vdc   = WR && ADDR == A_VDC;
  wire wr_vgn   = WR && ADDR == A_VGN;
  wire wr_cyc   = WR && ADDR == A_CYC;
  wire wr_prate = WR && ADDR == A_PRATE;
  wire wr_eps   = WR && ADDR == A_EPS;
  wire wr_stat  = WR && ADDR == A_ISTAT;
  wire wr_mask  = WR && ADDR == A_IMASK;

  // Calibration results win over a host write in the same cycle.
  wire cal_i = CAL.valid && CAL.do_i;
  wire cal_v = CAL.valid && CAL.do_v;
  wire cal_off = CAL.is_offset;

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_reg <= R_SETUP;
      idc_reg   <= R_ZERO;
      vdc_reg   <= R_ZERO;
      ign_reg   <= R_GAIN;
      vgn_reg   <= R_GAIN;
      cyc_reg   <= R_CYC;
      prate_reg <= R_PRATE;
      eps_reg   <= R_EPS;
      mask_reg  <= '0;
    end
    else
    begin
      if (wr_setup) setup_reg <= WDATA & SETUP_WMASK;
      if (cal_i && cal_off) idc_reg <= CAL.i_val;
      else if (wr_idc) idc_reg <= WDATA;
      if (cal_v && cal_off) vdc_reg <= CAL.v_val;
      else if (wr_vdc) vdc_reg <= WDATA;
      if (cal_i && !cal_off) ign_reg <= CAL.i_val;
      else if (wr_ign) ign_reg <= WDATA;
      if (cal_v && !cal_off) vgn_reg <= CAL.v_val;
      else if (wr_vgn) vgn_reg <= WDATA;
      if (wr_cyc) cyc_reg <= WDATA;
      if (wr_prate) prate_reg <= WDATA;
      if (EPS_VALID) eps_reg <= EPS_MEAS;
      else if (wr_eps) eps_reg <= WDATA;
      if (wr_mask) mask_reg <= WDATA[NEV-1:0];
    end
  end

  assign PHASE_DELAY_FIELD = setup_reg[F_PH_HI:F_PH_LO];
  assign CURRENT_GAIN_HIGH = setup_reg[F_GAIN];

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: one tick of the internal clock every K reference cycles.
  wire [4:0] div_k = (setup_reg[F_DIV_HI:0] == 4'h0) ? DIV_ZERO_AS : {1'b0, setup_reg[F_DIV_HI:0]};
  logic [4:0] dcnt_reg;
  logic internal_divided_clock_reg, cpu_reg;
  wire dtick = (dcnt_reg >= div_k - 5'h01);
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) begin dcnt_reg <= '0; internal_divided_clock_reg <= 1'b0; cpu_reg <= 1'b0; end
    else
    begin
      dcnt_reg <= dtick ? 5'h00 : dcnt_reg + 5'h01;
      internal_divided_clock_reg <= (dcnt_reg < (div_k >> 1)) || div_k == 5'h01;
      cpu_reg  <= setup_reg[F_CINV] ? !((dcnt_reg < (div_k >> 1)) || div_k == 5'h01)
                                    :  ((dcnt_reg < (div_k >> 1)) || div_k == 5'h01);
    end
  end
  assign INTERNAL_DIVIDED_CLOCK = internal_divided_clock_reg;
  assign PROCESSOR_CLOCK_OUTPUT = cpu_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Computation cycle: 1024 internal ticks per conversion slot, N slots.
  logic [9:0]  sub_reg;
  mpr_word_t   ncnt_reg;
  logic        cyc_end_reg;
  wire slot_end = dtick && sub_reg == CONV_PER_INTERNAL_DIVIDED_CLOCK;
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) begin sub_reg <= '0; ncnt_reg <= '0; cyc_end_reg <= 1'b0; end
    else
    begin
      if (dtick) sub_reg <= sub_reg + 10'h001;
      cyc_end_reg <= 1'b0;
      if (slot_end)
      begin
        if (ncnt_reg + 24'h000001 >= cyc_reg)
        begin
          ncnt_reg <= '0;
          cyc_end_reg <= 1'b1;
        end
        else ncnt_reg <= ncnt_reg + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurements: product, averaged power and RMS over a cycle.
  wire signed [47:0] prod  = $signed(CONV.v_smp) * $signed(CONV.i_smp);
  wire [47:0]        isq   = prod_sq(CONV.i_smp);
  wire [47:0]        vsq   = prod_sq(CONV.v_smp);
  logic signed [71:0] pacc_reg;
  logic [71:0] iacc_reg, vacc_reg;
  logic [23:0] nsmp_reg;

  function automatic logic [47:0] prod_sq(input mpr_word_t x);
    logic signed [47:0] s;
    s = $signed(x) * $signed(x);
    return s;
  endfunction

  // Root of a mean square that the caller has shifted up by two bits, so the
  // root carries 24 fraction bits; a full-scale mean saturates at all ones.
  function automatic mpr_word_t isqrt48(input logic [49:0] v);
    logic [23:0] r;
    r = '0;
    for (int b = 23; b >= 0; b--)
    begin
      r[b] = 1'b1;
      if ({26'h0000000, r} * {26'h0000000, r} > v) r[b] = 1'b0;
    end
    return r;
  endfunction

  wire [23:0] nsafe = (nsmp_reg == 24'h000000) ? 24'h000001 : nsmp_reg;
  wire signed [71:0] pavg_full = pacc_reg / $signed({48'h0, nsafe});
  wire [71:0] imean = iacc_reg / {48'h0, nsafe};
  wire [71:0] vmean = vacc_reg / {48'h0, nsafe};

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iinst_reg <= '0; vinst_reg <= '0; pinst_reg <= '0; pavg_reg <= '0;
      current_rms_result_reg <= '0; voltage_rms_result_reg <= '0; pacc_reg <= '0; iacc_reg <= '0; vacc_reg <= '0; nsmp_reg <= '0;
    end
    else
    begin
      if (CONV.valid)
      begin
        iinst_reg <= CONV.i_smp;
        vinst_reg <= CONV.v_smp;
        pinst_reg <= prod[46:23];
      end
      if (cyc_end_reg)
      begin
        pavg_reg <= pavg_full[46:23];
        current_rms_result_reg <= isqrt48({imean[47:0], 2'h0});
        voltage_rms_result_reg <= isqrt48({vmean[47:0], 2'h0});
        pacc_reg <= CONV.valid ? 72'(prod) : '0;
        iacc_reg <= CONV.valid ? {24'h0, isq} : '0;
        vacc_reg <= CONV.valid ? {24'h0, vsq} : '0;
        nsmp_reg <= CONV.valid ? 24'h000001 : '0;
      end
      else if (CONV.valid)
      begin
        pacc_reg <= pacc_reg + 72'(prod);
        iacc_reg <= iacc_reg + {24'h0, isq};
        vacc_reg <= vacc_reg + {24'h0, vsq};
        nsmp_reg <= nsmp_reg + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy pulses: a phase accumulator adds |rate| each reference cycle.
  wire [23:0] rate_mag = prate_reg[DW-1] ? (~prate_reg + 24'h000001) : prate_reg;
  logic [34:0] pacc2_reg;
  logic [1:0]  pw_reg;
  wire [34:0] pnext = pacc2_reg + {11'h000, rate_mag};
  wire pfire = pnext[34];
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) begin pacc2_reg <= '0; pw_reg <= '0; end
    else
    begin
      pacc2_reg <= {1'b0, pnext[33:0]};
      pw_reg <= pfire ? PULSE_TICKS : (pw_reg != 2'h0 ? pw_reg - 2'h1 : 2'h0);
    end
  end
  // Pulses are active low; open-drain mode only drives the low level on pulses 0 and 1, pulse 2 is always driven.
  wire pulse_lo = pw_reg != 2'h0;
  assign ENERGY_PULSE_O  = pulse_lo ? 3'h0 : 3'h7;
  assign ENERGY_PULSE_OE = setup_reg[F_OD] ? {1'b1, {2{pulse_lo}}} : 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt; a new event wins over a write-one clear.
  wire [NEV-1:0] ev = {EPS_VALID, CAL.valid, cyc_end_reg};
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) stat_reg <= '0;
    else stat_reg <= (stat_reg & ~(wr_stat ? WDATA[NEV-1:0] : '0)) | ev;
  end
  assign CALC_DONE_FLAG = stat_reg[EV_CALC] | stat_reg[EV_CAL];

  wire irq = |(stat_reg & mask_reg);
  logic irq_d_reg, int_reg;
  wire [1:0] sty = setup_reg[F_STY_HI:F_STY_LO];
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) begin irq_d_reg <= 1'b0; int_reg <= 1'b1; end
    else
    begin
      irq_d_reg <= irq;
      case (mpr_style_e'(sty))
        STY_LOW_LEVEL:  int_reg <= !irq;
        STY_HIGH_LEVEL: int_reg <= irq;
        STY_FALL_PULSE: int_reg <= !(irq && !irq_d_reg);
        STY_RISE_PULSE: int_reg <= irq && !irq_d_reg;
        default:        int_reg <= !irq;
      endcase
    end
  end
  assign INT_PIN = int_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; results are read-only.
  mpr_word_t rsel, rdata_reg;
  always_comb
  begin
    case (ADDR)
      A_SETUP: rsel = setup_reg;
      A_IDC:   rsel = idc_reg;
      A_IGN:   rsel = ign_reg;
      A_VDC:   rsel = vdc_reg;
      A_VGN:   rsel = vgn_reg;
      A_CYC:   rsel = cyc_reg;
      A_PRATE: rsel = prate_reg;
      A_IINST: rsel = iinst_reg;
      A_VINST: rsel = vinst_reg;
      A_PINST: rsel = pinst_reg;
      A_PAVG:  rsel = pavg_reg;
      A_CURRENT_RMS_RESULT:  rsel = current_rms_result_reg;
      A_VOLTAGE_RMS_RESULT:  rsel = voltage_rms_result_reg;
      A_EPS:   rsel = eps_reg;
      A_ISTAT: rsel = {21'h0, stat_reg};
      A_IMASK: rsel = {21'h0, mask_reg};
      default: rsel = R_ZERO;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n) rdata_reg <= '0;
    else rdata_reg <= RD ? rsel : R_ZERO;
  end
  assign RDATA = rdata_reg;

endmodule

// [core/mpr_pkg.sv]
/*
  Constants, register map and field layout of the page-zero register bank.
  Assumes a single 20 MHz reference clock and a plain strobe register port.
*/
package mpr_pkg;
  localparam int unsigned DW = 24;
  localparam int unsigned AW = 5;
  typedef logic [DW-1:0] mpr_word_t;

  localparam logic [AW-1:0] A_SETUP   = 5'h00;
  localparam logic [AW-1:0] A_IDC     = 5'h01;
  localparam logic [AW-1:0] A_IGN     = 5'h02;
  localparam logic [AW-1:0] A_VDC     = 5'h03;
  localparam logic [AW-1:0] A_VGN     = 5'h04;
  localparam logic [AW-1:0] A_CYC     = 5'h05;
  localparam logic [AW-1:0] A_PRATE   = 5'h06;
  localparam logic [AW-1:0] A_IINST   = 5'h07;
  localparam logic [AW-1:0] A_VINST   = 5'h08;
  localparam logic [AW-1:0] A_PINST   = 5'h09;
  localparam logic [AW-1:0] A_PAVG    = 5'h0A;
  localparam logic [AW-1:0] A_CURRENT_RMS_RESULT    = 5'h0B;
  localparam logic [AW-1:0] A_VOLTAGE_RMS_RESULT    = 5'h0C;
  localparam logic [AW-1:0] A_EPS     = 5'h0D;
  localparam logic [AW-1:0] A_ISTAT   = 5'h0E;
  localparam logic [AW-1:0] A_IMASK   = 5'h0F;

  localparam mpr_word_t R_SETUP = 24'h000001;
  localparam mpr_word_t R_ZERO  = 24'h000000;
  localparam mpr_word_t R_GAIN  = 24'h400000;
  localparam mpr_word_t R_CYC   = 24'h000FA0;
  localparam mpr_word_t R_PRATE = 24'h800000;
  localparam mpr_word_t R_EPS   = 24'h01999A;

  // Writable bits of the setup word; reserved bits stay zero.
  localparam mpr_word_t SETUP_WMASK = 24'hFF981F;

  localparam int unsigned F_PH_HI = 23;
  localparam int unsigned F_PH_LO = 17;
  localparam int unsigned F_GAIN  = 16;
  localparam int unsigned F_OD    = 15;
  localparam int unsigned F_STY_HI = 12;
  localparam int unsigned F_STY_LO = 11;
  localparam int unsigned F_CINV  = 4;
  localparam int unsigned F_DIV_HI = 3;

  localparam logic [4:0]  DIV_ZERO_AS = 5'h10;
  localparam logic [9:0]  CONV_PER_INTERNAL_DIVIDED_CLOCK = 10'h3FF;
  localparam logic [10:0] PULSE_DEN_M1 = 11'h7FF;
  localparam logic [1:0]  PULSE_TICKS = 2'h3;

  // Interrupt event bits.
  localparam int unsigned EV_CALC = 0;
  localparam int unsigned EV_CAL  = 1;
  localparam int unsigned EV_EPS  = 2;
  localparam int unsigned NEV     = 3;

  typedef enum logic [1:0] {
    STY_LOW_LEVEL  = 2'b00,
    STY_HIGH_LEVEL = 2'b01,
    STY_FALL_PULSE = 2'b10,
    STY_RISE_PULSE = 2'b11
  } mpr_style_e;

  // Calibration request from the sequencer outside this bank.
  typedef struct packed {
    logic      valid;
    logic      is_offset;
    logic      do_i;
    logic      do_v;
    mpr_word_t i_val;
    mpr_word_t v_val;
  } mpr_cal_s;

  // One conversion from the measurement front end.
  typedef struct packed {
    logic      valid;
    mpr_word_t i_smp;
    mpr_word_t v_smp;
  } mpr_conv_s;
endpackage

// [verif/meter_page0_register_bank_tb_top.sv]
/*
  Self-checking bench for the page-zero register bank.
  Assumes the front-end model and the checker bound at the foot.
*/
`timescale 1ns/10ps
module meter_page0_register_bank_tb_top
  import mpr_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [4:0] addr = 5'h00;
  mpr_word_t  wdata = 24'h000000;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  mpr_word_t  rdata, eps_m;
  mpr_conv_s  conv;
  mpr_cal_s   cal;
  logic [2:0] ep_o;
  logic       eps_v, gain_hi, internal_divided_clock, irq, done;
  int         n_errors = 0;
  int         checked = 0;
  int         n;
  localparam logic [4:0] TA [8] = '{A_SETUP, A_IDC, A_IGN, A_VDC, A_VGN, A_CYC, A_PRATE, A_EPS};
  localparam mpr_word_t  TV [8] = '{R_SETUP, R_ZERO, R_GAIN, R_ZERO, R_GAIN, R_CYC, R_PRATE, R_EPS};
  localparam mpr_word_t  RATES [2] = '{24'h400000, 24'hC00000};

  // Half period of the 20 MHz clock.
  always #25 clk = ~clk;

  mpr_bank dut_u (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CONV(conv), .CAL(cal), .EPS_VALID(eps_v), .EPS_MEAS(eps_m), .PHASE_DELAY_FIELD(), .CURRENT_GAIN_HIGH(gain_hi),
    .INTERNAL_DIVIDED_CLOCK(internal_divided_clock), .PROCESSOR_CLOCK_OUTPUT(), .ENERGY_PULSE_O(ep_o), .ENERGY_PULSE_OE(),
    .INT_PIN(irq), .CALC_DONE_FLAG(done));
  mpr_front_model front_u (.ref_clk(clk), .conv(conv), .cal(cal), .eps_valid(eps_v), .eps_meas(eps_m));

  task automatic chk(input string what, input mpr_word_t exp, input mpr_word_t got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes drop after one edge; an idle edge follows so no task reassigns them at once.
  task automatic wr_reg(input logic [4:0] a, input mpr_word_t v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a, input mpr_word_t exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(what, exp, rdata);
    @(posedge clk);
  endtask

  // Cycles between two rises of the divided clock (m 0) or two pulse starts (m 1).
  task automatic period(input int m, output int p);
    logic prev, cur;
    int   t0;
    p = 0;
    prev = 1'b1;
    t0 = -1;
    for (int i = 0; i < 20000 && p == 0; i++)
    begin
      @(negedge clk);
      cur = (m == 0) ? internal_divided_clock : !ep_o[0];
      if (cur && !prev)
        if (t0 >= 0) p = i - t0;
        else t0 = i;
      prev = cur;
    end
    if (p == 0)
    begin
      n_errors++;
      give_verdict();
    end
    else
      @(posedge clk);
  endtask

  // Waits at falling edges for the done flag; the bound covers one two-slot
  // cycle at a divide ratio of one, and running past it counts as a hang.
  task automatic wait_done;
    int i;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (done !== 1'b1 && i < 2100);
    if (done !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
    else
      @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    n = 1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (TA[i]) rd_chk("reset value", TA[i], TV[i]);
    $display("test reset values done");
    wr_reg(A_SETUP, 24'hFF981F);
    rd_chk("setup all fields", A_SETUP, 24'hFF981F);
    chk("gain high", 24'h000001, {23'h000000, gain_hi});
    front_u.send_conv(24'h400000, 24'h400000);
    wr_reg(A_IINST, 24'h123456);
    rd_chk("inst current", A_IINST, 24'h400000);
    rd_chk("inst power", A_PINST, 24'h200000);
    $display("test setup and samples done");
    period(0, n);
    chk("divide by fifteen", 24'h00000F, 24'(n));
    wr_reg(A_SETUP, 24'h000000);
    period(0, n);
    chk("divide by zero code", 24'h000010, 24'(n));
    wr_reg(A_SETUP, 24'h000003);
    period(0, n);
    chk("divide by three", 24'h000003, 24'(n));
    $display("test divider done");
    wr_reg(A_SETUP, 24'h008000);
    rd_chk("setup open drain", A_SETUP, 24'h008000);
    foreach (RATES[i])
    begin
      wr_reg(A_PRATE, RATES[i]);
      period(1, n);
      chk("pulse period", 24'h001000, 24'(n));
    end
    $display("test pulse rate done");
    wr_reg(A_IMASK, 24'h000002);
    front_u.send_cal(1'b1, 24'h111111, 24'h222222);
    rd_chk("current offset", A_IDC, 24'h111111);
    rd_chk("voltage offset", A_VDC, 24'h222222);
    front_u.send_cal(1'b0, 24'h6AAAAA, 24'hFFFFFF);
    rd_chk("current gain", A_IGN, 24'h6AAAAA);
    rd_chk("voltage gain", A_VGN, 24'hFFFFFF);
    chk("done flag", 24'h000001, {23'h000000, done});
    chk("irq low level", 24'h000000, {23'h000000, irq});
    wr_reg(A_SETUP, 24'h000800);
    @(negedge clk) chk("irq high level", 24'h000001, {23'h000000, irq});
    @(posedge clk) wr_reg(A_IMASK, 24'h000000);
    @(negedge clk) chk("irq masked", 24'h000000, {23'h000000, irq});
    @(posedge clk) wr_reg(A_ISTAT, 24'h000007);
    rd_chk("status cleared", A_ISTAT, 24'h000000);
    $display("test calibration and interrupt done");
    front_u.send_eps(24'h012345);
    rd_chk("ratio measured", A_EPS, 24'h012345);
    rd_chk("ratio status", A_ISTAT, 24'h000004);
    wr_reg(A_EPS, 24'h00ABCD);
    rd_chk("ratio written", A_EPS, 24'h00ABCD);
    $display("test line ratio done");
    // Divide by one, two slots per cycle, falling-pulse interrupt on cycle end.
    wr_reg(A_SETUP, 24'h001001);
    wr_reg(A_CYC, 24'h000002);
    wr_reg(A_IMASK, 24'h000001);
    wait_done();
    wr_reg(A_ISTAT, 24'h000007);
    wait_done();
    @(negedge clk) chk("irq falling pulse", 24'h000000, {23'h000000, irq});
    @(negedge clk) chk("irq pulse over", 24'h000001, {23'h000000, irq});
    @(posedge clk) front_u.send_conv(24'h400000, 24'h200000);
    @(posedge clk) front_u.send_conv(24'hC00000, 24'hE00000);
    wr_reg(A_ISTAT, 24'h000007);
    wait_done();
    rd_chk("average power", A_PAVG, 24'h100000);
    rd_chk("current rms", A_CURRENT_RMS_RESULT, 24'h800000);
    rd_chk("voltage rms", A_VOLTAGE_RMS_RESULT, 24'h400000);
    $display("test computation cycle done");
    give_verdict();
  end
endmodule

bind mpr_bank mpr_bank_checker chk_u (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
  .CAL(CAL), .EPS_VALID(EPS_VALID), .EPS_MEAS(EPS_MEAS), .PHASE_DELAY_FIELD(PHASE_DELAY_FIELD),
  .CURRENT_GAIN_HIGH(CURRENT_GAIN_HIGH), .INTERNAL_DIVIDED_CLOCK(INTERNAL_DIVIDED_CLOCK),
  .PROCESSOR_CLOCK_OUTPUT(PROCESSOR_CLOCK_OUTPUT), .ENERGY_PULSE_O(ENERGY_PULSE_O),
  .ENERGY_PULSE_OE(ENERGY_PULSE_OE), .CALC_DONE_FLAG(CALC_DONE_FLAG));

// [verif/mpr_bank_checker.sv]
/*
  Port-level assertions for the page-zero register bank.
  Assumes it is bound into mpr_bank and sees only its ports.
*/
`timescale 1ns/10ps
module mpr_bank_checker
  import mpr_pkg::*;
(
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       NRST,
  // Register port
  input wire logic [4:0] ADDR,
  input wire logic       RD,
  input wire mpr_word_t  RDATA,
  // Calibration and ratio inputs
  input wire mpr_cal_s   CAL,
  input wire logic       EPS_VALID,
  input wire mpr_word_t  EPS_MEAS,
  // Watched outputs
  input wire logic [6:0] PHASE_DELAY_FIELD,
  input wire logic       CURRENT_GAIN_HIGH,
  input wire logic       INTERNAL_DIVIDED_CLOCK,
  input wire logic       PROCESSOR_CLOCK_OUTPUT,
  input wire logic [2:0] ENERGY_PULSE_O,
  input wire logic [2:0] ENERGY_PULSE_OE,
  input wire logic       CALC_DONE_FLAG
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  // A setup read exposes the stored word, so outputs can be tied to it.
  wire setup_rd = RD && (ADDR == A_SETUP);

  // Multi-step cases: an update followed at once by a read of the target.
  sequence eps_then_read;
    EPS_VALID ##1 (RD && ADDR == A_EPS);
  endsequence
  sequence ioff_then_read;
    CAL.valid && CAL.is_offset && CAL.do_i ##1 (RD && ADDR == A_IDC);
  endsequence

  a_rdata_idle_zero: assert property (!RD |=> RDATA == R_ZERO)
    else $error("read data not zero outside a read");
  a_setup_reserved_zero: assert property (setup_rd |=> (RDATA & ~SETUP_WMASK) == R_ZERO)
    else $error("reserved setup bits read as one");
  a_setup_drives_analog: assert property (setup_rd |=> {PHASE_DELAY_FIELD, CURRENT_GAIN_HIGH} == RDATA[23:16])
    else $error("phase or gain output differs from setup word");
  a_clock_invert_follows: assert property (setup_rd |=> (PROCESSOR_CLOCK_OUTPUT ^ INTERNAL_DIVIDED_CLOCK) == RDATA[F_CINV])
    else $error("processor clock polarity wrong");
  a_pulse_drive_style: assert property (setup_rd |=> ENERGY_PULSE_OE[1:0] == (RDATA[F_OD] ? ~ENERGY_PULSE_O[1:0] : 2'h3))
    else $error("pulse output enable wrong for drive style");
  a_pulse_three_low: assert property ($fell(ENERGY_PULSE_O[0]) |-> !ENERGY_PULSE_O[0] [*3] ##1 ENERGY_PULSE_O[0])
    else $error("energy pulse not three cycles long");
  a_eps_measured_read: assert property (eps_then_read |=> RDATA == $past(EPS_MEAS, 2))
    else $error("measured ratio not stored");
  a_cal_offset_read: assert property (ioff_then_read |=> RDATA == $past(CAL.i_val, 2))
    else $error("offset calibration not stored");
  a_cal_sets_done: assert property (CAL.valid |=> CALC_DONE_FLAG)
    else $error("done flag missing after calibration");
endmodule

// [verif/mpr_front_model.sv]
/*
  Behavioural front end and calibration sequencer feeding the bank.
  Assumes tasks are called just after a rising edge of ref_clk.
*/
`timescale 1ns/10ps
module mpr_front_model
  import mpr_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Toward the bank
  output mpr_conv_s conv,
  output mpr_cal_s  cal,
  output logic      eps_valid,
  output mpr_word_t eps_meas
);
  // Idle at time zero.
  initial
  begin
    conv = '0;
    cal = '0;
    eps_valid = 1'b0;
    eps_meas = R_ZERO;
  end

  // After each pulse the data turn to their inverse, so a stale capture shows.
  task automatic send_conv(input mpr_word_t i, input mpr_word_t v);
    conv <= '{1'b1, i, v};
    @(posedge ref_clk) conv <= '{1'b0, ~i, ~v};
  endtask

  task automatic send_cal(input logic off, input mpr_word_t i, input mpr_word_t v);
    cal <= '{1'b1, off, 1'b1, 1'b1, i, v};
    @(posedge ref_clk) cal <= '{1'b0, off, 1'b0, 1'b0, ~i, ~v};
  endtask

  task automatic send_eps(input mpr_word_t m);
    eps_valid <= 1'b1;
    eps_meas <= m;
    @(posedge ref_clk) eps_valid <= 1'b0;
    eps_meas <= ~m;
  endtask
endmodule
